// ==== rtl/cpu_cycle_timer.sv ====
// Instruction cycle sequencer: prices an instruction and plays out its bus.
// Operation
// - Long move is 4(1/0) plus source and destination costs, up to 36(7/2).
// - Indexed modes cost the same for word or long index register.
// - Standard totals include operation, result store and next word fetch.
// - Flagged entries add the operand address clocks, reads and writes.
// - Long add, sub, and, or base six grows to eight for register/immediate.
// - Exclusive-or to a data register only takes a data register source.
// - Word divide: 158 signed, 140 unsigned, one read, plus address time.
// - Word multiply takes 38 plus 2n clocks, at most 70, plus address time.
// - Unsigned multiply n is the count of ones in the source.
// - Signed multiply n counts 01/10 pairs in source with a zero below.
// - Immediate forms include fetching the immediate extension words.
// - Each bus cycle takes four clocks; wait states lengthen busy time, not the total.
// - Total n holds r reads, w writes; remaining clocks are bus idle.
`timescale 1ns/100ps
module cpu_cycle_timer
	import cpu_timing_pkg::*;
(
	input  logic                              SYS_CLK,
	input  logic                              RST,
	input  logic                              START,
	input  logic [cpu_timing_pkg::OP_W-1:0]   OP,
	input  logic                              SIZE_LONG,
	input  logic [1:0]                        DST_KIND,
	input  logic [cpu_timing_pkg::MODE_W-1:0] SRC_MODE,
	input  logic [cpu_timing_pkg::MODE_W-1:0] DST_MODE,
	input  logic [cpu_timing_pkg::DATA_W-1:0] SRC_DATA,
	input  logic                              BUS_WAIT,
	output logic                              BUSY,
	output logic                              BUS_READ,
	output logic                              BUS_WRITE,
	output logic                              BUS_IDLE,
	output logic                              DONE,
	output logic                              ILLEGAL,
	output logic [cpu_timing_pkg::CLK_W-1:0]  TOTAL_CLKS,
	output logic [cpu_timing_pkg::CNT_W-1:0]  READ_CNT,
	output logic [cpu_timing_pkg::CNT_W-1:0]  WRITE_CNT
);

	seq_s              s_ff;
	seq_s              nxt_s;
	logic [MULN_W-1:0] mul_n;
	cost_s             base;
	cost_s             ea;
	cost_s             cost;
	logic              legal;
	logic              is_long;
	logic              src_dreg;
	logic              src_fast;
	logic              dst_alterable;
	logic [CLK_W-1:0]  bus_clks;

	function automatic cost_s mk(input logic [CLK_W-1:0] c,
		input logic [CNT_W-1:0] r, input logic [CNT_W-1:0] w);
		cost_s x;
		x.clks = c;
		x.rd   = r;
		x.wr   = w;
		return x;
	endfunction

	// The index register size is not an input at all, so it cannot matter.
	function automatic cost_s ea_cost(input logic [MODE_W-1:0] mode,
		input logic lng);
		cost_s x;
		x = mk(EA_WORD_CLKS[mode], EA_WORD_READS[mode], '0);
		if (lng && mode >= EA_INDIRECT && mode <= EA_IMMEDIATE) begin
			x.clks = x.clks + LONG_EA_EXTRA_CLKS;
			x.rd   = x.rd + LONG_EA_EXTRA_READS;
		end
		return x;
	endfunction

	function automatic seq_e after(input logic [CLK_W-1:0] idle_left,
		input logic [CNT_W-1:0] wr_left);
		seq_e st;
		if (idle_left != '0) begin
			st = ST_INTERNAL;
		end else if (wr_left != '0) begin
			st = ST_WRITE;
		end else begin
			st = ST_IDLE;
		end
		return st;
	endfunction

	mul_term_count u_mul_term_count (
		.is_signed (OP == OP_SIGNED_MULTIPLY),
		.src       (SRC_DATA),
		.n         (mul_n)
	);

	// Price the requested instruction; ea is zero where no address is added.
	always_comb begin
		is_long       = SIZE_LONG;
		src_dreg      = (SRC_MODE == EA_DATA_REGISTER_OPERAND);
		src_fast      = src_dreg || SRC_MODE == EA_ADDRESS_REGISTER_OPERAND ||
			SRC_MODE == EA_IMMEDIATE;
		dst_alterable = DST_MODE >= EA_INDIRECT && DST_MODE <= EA_ABS_LONG;
		legal         = SRC_MODE <= EA_IMMEDIATE;
		base          = mk('0, '0, '0);
		ea            = ea_cost(SRC_MODE, is_long);
		case (OP)
			OP_MOVE_LONG: begin
				base = mk(MOVE_BASE_CLKS + MOVE_DST_CLKS[DST_MODE],
					ONE_CYCLE + MOVE_DST_READS[DST_MODE],
					dst_alterable ? MOVE_LONG_WRITES : '0);
				ea    = ea_cost(SRC_MODE, 1'b1);
				legal = legal && DST_MODE <= EA_ABS_LONG;
			end
			OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP: begin
				if (DST_KIND == DST_DATA_REG) begin
					base = mk(is_long ? REG_LONG_CLKS : REG_BW_CLKS,
						ONE_CYCLE, '0);
				end else if (DST_KIND == DST_ADDR_REG) begin
					legal = legal && (OP == OP_ADD || OP == OP_SUB ||
						OP == OP_CMP);
					base  = mk(OP == OP_CMP ? CMP_AREG_CLKS :
						(is_long ? REG_LONG_CLKS : AREG_BW_CLKS), ONE_CYCLE, '0);
				end else begin
					legal = OP != OP_CMP && src_dreg && dst_alterable &&
						DST_KIND == DST_MEMORY;
					base  = is_long ? mk(MEM_LONG_CLKS, ONE_CYCLE, TWO_CYCLES) :
						mk(MEM_BW_CLKS, ONE_CYCLE, ONE_CYCLE);
					ea    = ea_cost(DST_MODE, is_long);
				end
				if (OP != OP_CMP && is_long && base.clks == REG_LONG_CLKS &&
					src_fast) begin
					base.clks = REG_LONG_SLOW_CLKS;
				end
			end
			OP_EXCLUSIVE_OR: begin
				legal = src_dreg;
				if (DST_KIND == DST_DATA_REG) begin
					base = mk(is_long ? EOR_REG_LONG_CLKS : EOR_REG_BW_CLKS,
						ONE_CYCLE, '0);
					ea   = mk('0, '0, '0);
				end else begin
					legal = legal && dst_alterable && DST_KIND == DST_MEMORY;
					base  = is_long ? mk(MEM_LONG_CLKS, ONE_CYCLE, TWO_CYCLES) :
						mk(MEM_BW_CLKS, ONE_CYCLE, ONE_CYCLE);
					ea    = ea_cost(DST_MODE, is_long);
				end
			end
			OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE: begin
				legal = legal && !is_long && DST_KIND == DST_DATA_REG;
				base  = mk(OP == OP_SIGNED_DIVIDE ? SDIV_CLKS : UDIV_CLKS,
					ONE_CYCLE, '0);
				ea    = ea_cost(SRC_MODE, 1'b0);
			end
			OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY: begin
				legal = legal && !is_long && DST_KIND == DST_DATA_REG;
				base  = mk(MUL_BASE_CLKS + {2'b00, mul_n, 1'b0},
					ONE_CYCLE, '0);
				ea    = ea_cost(SRC_MODE, 1'b0);
			end
			OP_ADD_IMMEDIATE, OP_SUB_IMMEDIATE, OP_AND_IMMEDIATE,
			OP_OR_IMMEDIATE, OP_EOR_IMMEDIATE, OP_CMP_IMMEDIATE: begin
				// Extension word reads are part of each base figure.
				if (DST_KIND == DST_DATA_REG) begin
					ea = mk('0, '0, '0);
					if (!is_long) begin
						base = mk(IMM_REG_BW_CLKS, TWO_CYCLES, '0);
					end else if (OP == OP_AND_IMMEDIATE ||
						OP == OP_CMP_IMMEDIATE) begin
						base = mk(IMM_REG_LONG_SHORT, THREE_CYCLES, '0);
					end else begin
						base = mk(IMM_REG_LONG_CLKS, THREE_CYCLES, '0);
					end
				end else begin
					legal = legal && dst_alterable && DST_KIND == DST_MEMORY;
					ea    = ea_cost(DST_MODE, is_long);
					if (OP == OP_CMP_IMMEDIATE) begin
						base = is_long ?
							mk(CMPI_MEM_LONG_CLKS, THREE_CYCLES, '0) :
							mk(CMPI_MEM_BW_CLKS, TWO_CYCLES, '0);
					end else begin
						base = is_long ?
							mk(IMM_MEM_LONG_CLKS, THREE_CYCLES, TWO_CYCLES) :
							mk(IMM_MEM_BW_CLKS, TWO_CYCLES, ONE_CYCLE);
					end
				end
			end
			default: legal = 1'b0;
		endcase
		cost     = mk(base.clks + ea.clks, base.rd + ea.rd,
			base.wr + ea.wr);
		bus_clks = CLK_W'(({4'h0, cost.rd} + {4'h0, cost.wr}) *
			BUS_CYCLE_CLKS);
	end

	// Reads go first (the last one stands for the next-word fetch), then the
	// internal clocks, then the writes; waits hold the last clock of a cycle.
	always_comb begin
		nxt_s         = s_ff;
		nxt_s.done    = 1'b0;
		nxt_s.illegal = 1'b0;
		case (s_ff.state)
			ST_IDLE: begin
				if (START && !legal) begin
					nxt_s.illegal = 1'b1;
				end else if (START) begin
					nxt_s.state     = ST_READ;
					nxt_s.phase     = '0;
					nxt_s.rd_left   = cost.rd;
					nxt_s.wr_left   = cost.wr;
					nxt_s.idle_left = cost.clks - bus_clks;
					nxt_s.total     = cost.clks;
					nxt_s.reads     = cost.rd;
					nxt_s.writes    = cost.wr;
				end
			end
			ST_READ: begin
				if (s_ff.phase != LAST_PHASE) begin
					nxt_s.phase = s_ff.phase + 2'h1;
				end else if (!BUS_WAIT) begin
					nxt_s.phase   = '0;
					nxt_s.rd_left = s_ff.rd_left - ONE_CYCLE;
					if (s_ff.rd_left == ONE_CYCLE) begin
						nxt_s.state = after(s_ff.idle_left, s_ff.wr_left);
					end
				end
			end
			ST_INTERNAL: begin
				nxt_s.idle_left = s_ff.idle_left - 8'h01;
				if (s_ff.idle_left == 8'h01) begin
					nxt_s.state = after('0, s_ff.wr_left);
				end
			end
			ST_WRITE: begin
				if (s_ff.phase != LAST_PHASE) begin
					nxt_s.phase = s_ff.phase + 2'h1;
				end else if (!BUS_WAIT) begin
					nxt_s.phase   = '0;
					nxt_s.wr_left = s_ff.wr_left - ONE_CYCLE;
					if (s_ff.wr_left == ONE_CYCLE) begin
						nxt_s.state = ST_IDLE;
					end
				end
			end
			default: nxt_s.state = ST_IDLE;
		endcase
		nxt_s.busy      = nxt_s.state != ST_IDLE;
		nxt_s.bus_read  = nxt_s.state == ST_READ;
		nxt_s.bus_write = nxt_s.state == ST_WRITE;
		nxt_s.bus_idle  = nxt_s.state == ST_INTERNAL;
		nxt_s.done      = s_ff.busy && !nxt_s.busy;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			s_ff <= SEQ_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign BUSY       = s_ff.busy;
	assign BUS_READ   = s_ff.bus_read;
	assign BUS_WRITE  = s_ff.bus_write;
	assign BUS_IDLE   = s_ff.bus_idle;
	assign DONE       = s_ff.done;
	assign ILLEGAL    = s_ff.illegal;
	assign TOTAL_CLKS = s_ff.total;
	assign READ_CNT   = s_ff.reads;
	assign WRITE_CNT  = s_ff.writes;

endmodule

// ==== rtl/cpu_timing_pkg.sv ====
// Shared constants, types and cost tables of the instruction cycle timer.
package cpu_timing_pkg;

	localparam int OP_W   = 5;
	localparam int MODE_W = 4;
	localparam int CLK_W  = 8;
	localparam int CNT_W  = 4;
	localparam int DATA_W = 16;
	localparam int MULN_W = 5;

	// Baseline bus cycle length in clocks; wait states stretch its last clock.
	localparam logic [CLK_W-1:0] BUS_CYCLE_CLKS = 8'h04;
	localparam logic [1:0]       LAST_PHASE     = 2'h3;

	typedef enum logic [OP_W-1:0] {
		OP_MOVE_LONG        = 5'h00,
		OP_ADD              = 5'h01,
		OP_SUB              = 5'h02,
		OP_AND              = 5'h03,
		OP_OR               = 5'h04,
		OP_CMP              = 5'h05,
		OP_EXCLUSIVE_OR     = 5'h06,
		OP_SIGNED_DIVIDE    = 5'h07,
		OP_UNSIGNED_DIVIDE  = 5'h08,
		OP_SIGNED_MULTIPLY  = 5'h09,
		OP_UNSIGNED_MULTIPLY = 5'h0A,
		OP_ADD_IMMEDIATE    = 5'h0B,
		OP_SUB_IMMEDIATE    = 5'h0C,
		OP_AND_IMMEDIATE    = 5'h0D,
		OP_OR_IMMEDIATE     = 5'h0E,
		OP_EOR_IMMEDIATE    = 5'h0F,
		OP_CMP_IMMEDIATE    = 5'h10
	} op_e;

	typedef enum logic [MODE_W-1:0] {
		EA_DATA_REGISTER_OPERAND    = 4'h0,
		EA_ADDRESS_REGISTER_OPERAND = 4'h1,
		EA_INDIRECT                 = 4'h2,
		EA_POSTINC                  = 4'h3,
		EA_PREDEC                   = 4'h4,
		EA_DISP16                   = 4'h5,
		EA_INDEXED                  = 4'h6,
		EA_ABS_SHORT                = 4'h7,
		EA_ABS_LONG                 = 4'h8,
		EA_PC_DISP                  = 4'h9,
		EA_PC_INDEXED               = 4'hA,
		EA_IMMEDIATE                = 4'hB
	} ea_mode_e;

	typedef enum logic [1:0] {
		DST_DATA_REG = 2'b00,
		DST_ADDR_REG = 2'b01,
		DST_MEMORY   = 2'b10
	} dst_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_READ     = 2'b01,
		ST_INTERNAL = 2'b10,
		ST_WRITE    = 2'b11
	} seq_e;

	typedef struct packed {
		logic [CLK_W-1:0] clks;
		logic [CNT_W-1:0] rd;
		logic [CNT_W-1:0] wr;
	} cost_s;

	typedef struct packed {
		seq_e             state;
		logic [1:0]       phase;
		logic [CNT_W-1:0] rd_left;
		logic [CNT_W-1:0] wr_left;
		logic [CLK_W-1:0] idle_left;
		logic             busy;
		logic             bus_read;
		logic             bus_write;
		logic             bus_idle;
		logic             done;
		logic             illegal;
		logic [CLK_W-1:0] total;
		logic [CNT_W-1:0] reads;
		logic [CNT_W-1:0] writes;
	} seq_s;

	localparam seq_s SEQ_RESET = '0;

	// Operand address cost for byte and word operands, indexed by mode.
	localparam logic [CLK_W-1:0] EA_WORD_CLKS [0:15] = '{
		8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h08,
		8'h0C, 8'h08, 8'h0A, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [CNT_W-1:0] EA_WORD_READS [0:15] = '{
		4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
		4'h3, 4'h2, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
	localparam logic [CLK_W-1:0] LONG_EA_EXTRA_CLKS  = 8'h04;
	localparam logic [CNT_W-1:0] LONG_EA_EXTRA_READS = 4'h1;

	// Destination part of a long move, indexed by destination mode.
	localparam logic [CLK_W-1:0] MOVE_DST_CLKS [0:15] = '{
		8'h00, 8'h00, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0E, 8'h0C,
		8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [CNT_W-1:0] MOVE_DST_READS [0:15] = '{
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1,
		4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
	localparam logic [CNT_W-1:0] MOVE_LONG_WRITES = 4'h2;
	localparam logic [CLK_W-1:0] MOVE_BASE_CLKS   = 8'h04;

	localparam logic [CLK_W-1:0] REG_BW_CLKS        = 8'h04;
	localparam logic [CLK_W-1:0] REG_LONG_CLKS      = 8'h06;
	localparam logic [CLK_W-1:0] REG_LONG_SLOW_CLKS = 8'h08;
	localparam logic [CLK_W-1:0] AREG_BW_CLKS       = 8'h08;
	localparam logic [CLK_W-1:0] CMP_AREG_CLKS      = 8'h06;
	localparam logic [CLK_W-1:0] MEM_BW_CLKS        = 8'h08;
	localparam logic [CLK_W-1:0] MEM_LONG_CLKS      = 8'h0C;
	localparam logic [CLK_W-1:0] EOR_REG_BW_CLKS    = 8'h04;
	localparam logic [CLK_W-1:0] EOR_REG_LONG_CLKS  = 8'h08;
	localparam logic [CLK_W-1:0] SDIV_CLKS          = 8'h9E;
	localparam logic [CLK_W-1:0] UDIV_CLKS          = 8'h8C;
	localparam logic [CLK_W-1:0] MUL_BASE_CLKS      = 8'h26;
	localparam logic [CLK_W-1:0] IMM_REG_BW_CLKS    = 8'h08;
	localparam logic [CLK_W-1:0] IMM_REG_LONG_CLKS  = 8'h10;
	localparam logic [CLK_W-1:0] IMM_REG_LONG_SHORT = 8'h0E;
	localparam logic [CLK_W-1:0] IMM_MEM_BW_CLKS    = 8'h0C;
	localparam logic [CLK_W-1:0] IMM_MEM_LONG_CLKS  = 8'h14;
	localparam logic [CLK_W-1:0] CMPI_MEM_BW_CLKS   = 8'h08;
	localparam logic [CLK_W-1:0] CMPI_MEM_LONG_CLKS = 8'h0C;

	localparam logic [CNT_W-1:0] ONE_CYCLE    = 4'h1;
	localparam logic [CNT_W-1:0] TWO_CYCLES   = 4'h2;
	localparam logic [CNT_W-1:0] THREE_CYCLES = 4'h3;

endpackage

// ==== rtl/mul_term_count.sv ====
// Data-dependent term count n for the word multiply timing.
`timescale 1ns/100ps
module mul_term_count
	import cpu_timing_pkg::*;
(
	input  logic              is_signed,
	input  logic [DATA_W-1:0] src,
	output logic [MULN_W-1:0] n
);

	logic [DATA_W-1:0] bits;

	// Signed: {src,0} pairs differ where src[i] differs from src[i-1].
	always_comb begin
		if (is_signed) begin
			bits = src ^ {src[DATA_W-2:0], 1'b0};
		end else begin
			bits = src;
		end
		n = '0;
		for (int i = 0; i < DATA_W; i++) begin
			n = n + MULN_W'(bits[i]);
		end
	end

endmodule

// ==== verification/cpu_cycle_timer_asserts.sv ====
// Port-level temporal checks of the instruction cycle timer.
`timescale 1ns/100ps
module cpu_cycle_timer_chk
	import cpu_timing_pkg::*;
(
	input logic              SYS_CLK,
	input logic              RST,
	input logic              START,
	input logic [OP_W-1:0]   OP,
	input logic              SIZE_LONG,
	input logic [1:0]        DST_KIND,
	input logic [MODE_W-1:0] SRC_MODE,
	input logic [MODE_W-1:0] DST_MODE,
	input logic [DATA_W-1:0] SRC_DATA,
	input logic              BUS_WAIT,
	input logic              BUSY,
	input logic              BUS_READ,
	input logic              BUS_WRITE,
	input logic              BUS_IDLE,
	input logic              DONE,
	input logic              ILLEGAL,
	input logic [CLK_W-1:0]  TOTAL_CLKS,
	input logic [CNT_W-1:0]  READ_CNT,
	input logic [CNT_W-1:0]  WRITE_CNT
);
	logic take;
	logic word_reg;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	assign take = START && !BUSY;
	assign word_reg = SRC_MODE == 4'h0 && !SIZE_LONG && DST_KIND == 2'h0;

	one_phase_a: assert property (BUSY |->
		$onehot({BUS_READ, BUS_WRITE, BUS_IDLE}))
		else $error("Busy clock is not in exactly one bus phase.");
	first_read_a: assert property ($rose(BUSY) |-> BUS_READ)
		else $error("Instruction did not open with a read.");
	read_len_a: assert property ($rose(BUS_READ) |-> BUS_READ[*4])
		else $error("Read cycle shorter than four clocks.");
	write_len_a: assert property ($rose(BUS_WRITE) |-> BUS_WRITE[*4])
		else $error("Write cycle shorter than four clocks.");
	wait_hold_a: assert property (BUS_READ && BUS_WAIT |=> BUS_READ)
		else $error("Wait request did not hold the read.");
	done_end_a: assert property (DONE |-> !BUSY && $past(BUSY))
		else $error("Done pulse not right after the last busy clock.");
	xor_src_a: assert property (take && OP == OP_EXCLUSIVE_OR &&
		SRC_MODE != 4'h0 |=> ILLEGAL && !BUSY)
		else $error("Exclusive-or with a non data register source accepted.");
	xor_cost_a: assert property (take && OP == OP_EXCLUSIVE_OR &&
		word_reg |=> TOTAL_CLKS == 8'h04 && READ_CNT == 4'h1 &&
		WRITE_CNT == 4'h0)
		else $error("Exclusive-or word timing wrong.");
	div_cost_a: assert property (take && OP == OP_UNSIGNED_DIVIDE &&
		word_reg |=> TOTAL_CLKS == 8'h8C && READ_CNT == 4'h1)
		else $error("Unsigned divide timing wrong.");
	mul_cost_a: assert property (take && word_reg &&
		OP == OP_UNSIGNED_MULTIPLY |=> TOTAL_CLKS == 8'h26 +
		8'($countones($past(SRC_DATA))) * 8'h02)
		else $error("Unsigned multiply timing wrong.");

	cover property (DONE);
	cover property (ILLEGAL);
	cover property ($rose(BUS_WRITE));
	cover property (BUS_WAIT && BUS_READ);
endmodule

bind cpu_cycle_timer cpu_cycle_timer_chk chk_u (.SYS_CLK, .RST, .START, .OP,
	.SIZE_LONG, .DST_KIND, .SRC_MODE, .DST_MODE, .SRC_DATA, .BUS_WAIT, .BUSY,
	.BUS_READ, .BUS_WRITE, .BUS_IDLE, .DONE, .ILLEGAL, .TOTAL_CLKS, .READ_CNT,
	.WRITE_CNT);

// ==== verification/mem_responder.sv ====
// Memory-side model that stretches bus cycles with wait states.
`timescale 1ns/100ps
module mem_responder (
	input  logic clk,
	input  logic rst,
	input  logic slow,
	input  logic rd,
	input  logic wr,
	output logic bus_wait
);
	logic [2:0] pos_ff;

	// Slow memory holds the fourth clock of every cycle exactly once.
	assign bus_wait = slow && (rd || wr) && pos_ff == 3'h3;
	always_ff @(posedge clk) begin
		if (rst || !(rd || wr) || pos_ff == (slow ? 3'h4 : 3'h3))
			pos_ff <= 3'h0;
		else
			pos_ff <= pos_ff + 3'h1;
	end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the instruction cycle timer.
`timescale 1ns/100ps
module tb_top;
	import cpu_timing_pkg::*;
	logic              clk;
	logic              rst;
	logic              start;
	logic [OP_W-1:0]   op;
	logic              size_long;
	logic [1:0]        dst_kind;
	logic [MODE_W-1:0] src_mode;
	logic [MODE_W-1:0] dst_mode;
	logic [DATA_W-1:0] src_data;
	logic              bus_wait;
	logic              busy;
	logic              rd;
	logic              wr;
	logic              idle;
	logic              done;
	logic              illegal;
	logic [CLK_W-1:0]  total;
	logic [CNT_W-1:0]  rcnt;
	logic [CNT_W-1:0]  wcnt;
	logic              slow;
	logic [15:0]       lfsr;
	int                mismatches;
	int                tests_run;
	int                cycles;

	cpu_cycle_timer dut_u (.SYS_CLK(clk), .RST(rst), .START(start), .OP(op),
		.SIZE_LONG(size_long), .DST_KIND(dst_kind), .SRC_MODE(src_mode),
		.DST_MODE(dst_mode), .SRC_DATA(src_data), .BUS_WAIT(bus_wait),
		.BUSY(busy), .BUS_READ(rd), .BUS_WRITE(wr), .BUS_IDLE(idle),
		.DONE(done), .ILLEGAL(illegal), .TOTAL_CLKS(total), .READ_CNT(rcnt),
		.WRITE_CNT(wcnt));
	mem_responder resp_u (.clk(clk), .rst(rst), .slow(slow), .rd(rd),
		.wr(wr), .bus_wait(bus_wait));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A hang counts against the run instead of stalling it.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Signed n walks the 17-bit value with a zero below, pair by pair.
	function automatic logic [7:0] mul_clks(input logic sg,
		input logic [15:0] v);
		logic [16:0] e;
		logic [7:0]  c;
		e = {v, 1'b0};
		c = 8'h26;
		for (int i = 0; i < 16; i++)
			c += sg ? {e[i + 1] ^ e[i], 1'b0} : {v[i], 1'b0};
		return c;
	endfunction

	// Issues one request; START is held over one rising edge and drops at the returning falling edge.
	task automatic issue(input logic [4:0] o, input logic l, input logic [1:0] k,
		input logic [3:0] s, input logic [3:0] d);
		op = o;
		size_long = l;
		dst_kind = k;
		src_mode = s;
		dst_mode = d;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask

	task automatic run(input logic [4:0] o, input logic l, input logic [1:0] k,
		input logic [3:0] s, input logic [3:0] d, input logic [7:0] n,
		input logic [3:0] r, input logic [3:0] w);
		int bsy;
		int rdc;
		int wrc;
		int idc;
		bsy = 0;
		rdc = 0;
		wrc = 0;
		idc = 0;
		issue(o, l, k, s, d);
		while (busy === 1'b1 && bsy < 400) begin
			bsy++;
			rdc += rd;
			wrc += wr;
			idc += idle;
			@(negedge clk);
		end
		check(total, n);
		check(rcnt, r);
		check(wcnt, w);
		check(done, 1'b1);
		check(bsy, n + (slow ? r + w : 0));
		check(rdc, 4 * r + (slow ? r : 0));
		check(wrc, 4 * w + (slow ? w : 0));
		check(idc, n - 4 * (r + w));
	endtask

	task automatic bad(input logic [4:0] o, input logic l, input logic [1:0] k,
		input logic [3:0] s);
		issue(o, l, k, s, 4'h2);
		check(illegal, 1'b1);
		check(busy, 1'b0);
		@(negedge clk);
	endtask

	initial begin
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		lfsr = 16'h0025;
		slow = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		op = 5'h00;
		size_long = 1'b0;
		dst_kind = 2'h0;
		src_mode = 4'h0;
		dst_mode = 4'h0;
		src_data = 16'h0000;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		check(busy, 1'b0);
		check(total, 8'h00);
		@(negedge clk);
		run(OP_EXCLUSIVE_OR, 1'b0, DST_DATA_REG, 4'h0, 4'h0, 8'h04, 4'h1, 4'h0);
		run(OP_EXCLUSIVE_OR, 1'b1, DST_DATA_REG, 4'h0, 4'h0, 8'h08, 4'h1, 4'h0);
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'h0, 4'h0, 8'h04, 4'h1, 4'h0);
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'h8, 4'h8, 8'h24, 4'h7, 4'h2);
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'h0, 4'h2, 8'h0C, 4'h1, 4'h2);
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'h6, 4'h0, 8'h12, 4'h4, 4'h0);
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'hA, 4'h0, 8'h12, 4'h4, 4'h0);
		run(OP_ADD, 1'b1, DST_DATA_REG, 4'h0, 4'h0, 8'h08, 4'h1, 4'h0);
		run(OP_SUB, 1'b1, DST_DATA_REG, 4'hB, 4'h0, 8'h10, 4'h3, 4'h0);
		run(OP_ADD, 1'b1, DST_DATA_REG, 4'h2, 4'h0, 8'h0E, 4'h3, 4'h0);
		run(OP_OR, 1'b0, DST_DATA_REG, 4'h8, 4'h0, 8'h10, 4'h4, 4'h0);
		run(OP_ADD, 1'b0, DST_MEMORY, 4'h0, 4'h2, 8'h0C, 4'h2, 4'h1);
		run(OP_SIGNED_DIVIDE, 1'b0, DST_DATA_REG, 4'h0, 4'h0, 8'h9E, 4'h1, 4'h0);
		run(OP_UNSIGNED_DIVIDE, 1'b0, DST_DATA_REG, 4'h0, 4'h0, 8'h8C, 4'h1, 4'h0);
		for (int o = 11; o <= 16; o++) begin
			run(5'(o), 1'b0, DST_DATA_REG, 4'hB, 4'h0, 8'h08, 4'h2, 4'h0);
			run(5'(o), 1'b1, DST_DATA_REG, 4'hB, 4'h0,
				(o == 13 || o == 16) ? 8'h0E : 8'h10, 4'h3, 4'h0);
		end
		run(OP_ADD_IMMEDIATE, 1'b0, DST_MEMORY, 4'hB, 4'h2, 8'h10, 4'h3, 4'h1);
		for (int i = 0; i < 44; i++) begin
			lfsr = lfsr_next(lfsr);
			src_data = (i == 0) ? 16'h5555 : (i == 1) ? 16'hFFFF : lfsr;
			run(i[0] ? OP_UNSIGNED_MULTIPLY : OP_SIGNED_MULTIPLY, 1'b0,
				DST_DATA_REG, 4'h0, 4'h0, mul_clks(!i[0], src_data),
				4'h1, 4'h0);
		end
		slow = 1'b1;
		run(OP_MOVE_LONG, 1'b1, DST_MEMORY, 4'h8, 4'h8, 8'h24, 4'h7, 4'h2);
		run(OP_EXCLUSIVE_OR, 1'b1, DST_DATA_REG, 4'h0, 4'h0, 8'h08, 4'h1, 4'h0);
		slow = 1'b0;
		// Reset in the internal clocks of a divide must drop it cleanly.
		issue(OP_SIGNED_DIVIDE, 1'b0, DST_DATA_REG, 4'h0, 4'h0);
		repeat (8) @(negedge clk);
		check(idle, 1'b1);
		rst = 1'b1;
		@(negedge clk);
		check(busy, 1'b0);
		check(done, 1'b0);
		check(total, 8'h00);
		rst = 1'b0;
		run(OP_EXCLUSIVE_OR, 1'b0, DST_DATA_REG, 4'h0, 4'h0, 8'h04,
			4'h1, 4'h0);
		bad(OP_EXCLUSIVE_OR, 1'b0, DST_DATA_REG, 4'h1);
		bad(OP_SIGNED_DIVIDE, 1'b1, DST_DATA_REG, 4'h0);
		bad(5'h11, 1'b0, DST_DATA_REG, 4'h0);
		report_and_stop();
	end
endmodule
